//--- shared/pcfg_pkg.sv
package pcfg_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam int unsigned ADR_W = 4;
    localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADR_W-1:0] REG_WORD = 4'h8;
    localparam logic [ADR_W-1:0] REG_COUNT = 4'hc;

    localparam int unsigned CTRL_ENC = 0;
    localparam int unsigned CTRL_COMP = 1;
    localparam int unsigned CTRL_POR_STD = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    localparam int unsigned STAT_RELEASED = 0;
    localparam int unsigned STAT_MODE_ERR = 1;
    localparam int unsigned STAT_EARLY_CLK = 2;
    localparam int unsigned STAT_MID_WORD = 3;

    // ----------------------------------------------------------------
    // Clock-to-data ratios per bus width and stream mode
    // ----------------------------------------------------------------
    localparam logic [3:0] RATIO_PLAIN = 4'h1;
    localparam logic [3:0] RATIO_X8_ENC = 4'h1;
    localparam logic [3:0] RATIO_X8_COMP = 4'h2;
    localparam logic [3:0] RATIO_X16_ENC = 4'h2;
    localparam logic [3:0] RATIO_X16_COMP = 4'h4;
    localparam logic [3:0] RATIO_X32_ENC = 4'h4;
    localparam logic [3:0] RATIO_X32_COMP = 4'h8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned POR_FAST_MIN_MS = 4;
    localparam int unsigned POR_STD_MIN_MS = 100;
    localparam int unsigned FIRST_EDGE_MIN_US = 10;
    localparam int unsigned POR_FAST_CYC = POR_FAST_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned POR_STD_CYC = POR_STD_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned FIRST_EDGE_CYC = FIRST_EDGE_MIN_US * (CLK_HZ / 1000000);

    localparam int unsigned WORD_W = 32;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] data;
    } pcfg_word_type;

endpackage

//--- design/pcfg_intake.sv
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module pcfg_intake #(
    parameter int unsigned DATA_W = 32,
    parameter int unsigned POR_FAST_CYC = pcfg_pkg::POR_FAST_CYC,
    parameter int unsigned POR_STD_CYC = pcfg_pkg::POR_STD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [pcfg_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic supply_ok_i,
    input wire logic config_clock_i,
    input wire logic [DATA_W-1:0] config_data_i,
    output logic status_n_o,
    output pcfg_pkg::pcfg_word_type word_o
);

    initial begin
        if (!(DATA_W == 8 || DATA_W == 16 || DATA_W == 32)) begin
            $error("DATA_W must be 8, 16 or 32");
        end
        if (POR_FAST_CYC < 2 || POR_STD_CYC < 2) begin
            $error("power-on delays must be at least two cycles");
        end
    end

    // ----------------------------------------------------------------
    // Ratio lookup
    // ----------------------------------------------------------------
    function automatic logic [3:0] ratio_of(input logic enc, input logic comp);
        logic [3:0] r;
        r = pcfg_pkg::RATIO_PLAIN;
        if (DATA_W == 8) begin
            if (enc) r = pcfg_pkg::RATIO_X8_ENC;
            if (comp) r = pcfg_pkg::RATIO_X8_COMP;
        end else if (DATA_W == 16) begin
            if (enc) r = pcfg_pkg::RATIO_X16_ENC;
            if (comp) r = pcfg_pkg::RATIO_X16_COMP;
        end else begin
            if (enc) r = pcfg_pkg::RATIO_X32_ENC;
            if (comp) r = pcfg_pkg::RATIO_X32_COMP;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Data is delayed by the same two stages as the clock, so the word
    // seen at the detected edge is the one the host set up for it.
    logic sup_s1_r, sup_s2_r, ck_s1_r, ck_s2_r, ck_s3_r;
    logic [DATA_W-1:0] dat_s1_r, dat_s2_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            ck_s1_r <= 1'b0;
            ck_s2_r <= 1'b0;
            ck_s3_r <= 1'b0;
            dat_s1_r <= '0;
            dat_s2_r <= '0;
        end else begin
            sup_s1_r <= supply_ok_i;
            sup_s2_r <= sup_s1_r;
            ck_s1_r <= config_clock_i;
            ck_s2_r <= ck_s1_r;
            ck_s3_r <= ck_s2_r;
            dat_s1_r <= config_data_i;
            dat_s2_r <= dat_s1_r;
        end
    end

    logic ck_rise;
    assign ck_rise = ck_s2_r & ~ck_s3_r;

    // ----------------------------------------------------------------
    // Power-on delay
    // ----------------------------------------------------------------
    logic [2:0] ctrl_r;
    logic [31:0] por_cnt_r, por_cnt_nxt, por_target;
    logic released_r, released_nxt;

    assign por_target = ctrl_r[pcfg_pkg::CTRL_POR_STD] ? POR_STD_CYC : POR_FAST_CYC;

    always_comb begin
        por_cnt_nxt = por_cnt_r;
        released_nxt = released_r;
        if (!sup_s2_r) begin
            por_cnt_nxt = '0;
            released_nxt = 1'b0;
        end else if (!released_r) begin
            if (por_cnt_r >= por_target - 32'h1) begin
                released_nxt = 1'b1;
            end else begin
                por_cnt_nxt = por_cnt_r + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_cnt_r <= '0;
            released_r <= 1'b0;
        end else begin
            por_cnt_r <= por_cnt_nxt;
            released_r <= released_nxt;
        end
    end

    assign status_n_o = released_r;

    // ----------------------------------------------------------------
    // Word intake
    // ----------------------------------------------------------------
    logic [3:0] ratio, beat_r, beat_nxt;
    logic [DATA_W-1:0] word_r, word_nxt;
    logic valid_r, valid_nxt;
    logic [31:0] count_r, count_nxt;
    logic [15:0] gap_r, gap_nxt;
    logic early_ev;

    assign ratio = ratio_of(ctrl_r[pcfg_pkg::CTRL_ENC], ctrl_r[pcfg_pkg::CTRL_COMP]);
    // Edge before the settle time has run out: the host broke its wait
    assign early_ev = released_r & ck_rise & (gap_r < 16'(pcfg_pkg::FIRST_EDGE_CYC));

    always_comb begin
        beat_nxt = beat_r;
        word_nxt = word_r;
        valid_nxt = 1'b0;
        count_nxt = count_r;
        gap_nxt = gap_r;
        if (!released_r) begin
            beat_nxt = '0;
            gap_nxt = '0;
        end else begin
            if (gap_r < 16'(pcfg_pkg::FIRST_EDGE_CYC)) begin
                gap_nxt = gap_r + 16'h1;
            end
            if (ck_rise) begin
                if (beat_r == 4'h0) begin
                    word_nxt = dat_s2_r;
                end
                if (beat_r >= ratio - 4'h1) begin
                    beat_nxt = '0;
                    valid_nxt = 1'b1;
                    count_nxt = count_r + 32'h1;
                end else begin
                    beat_nxt = beat_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            beat_r <= '0;
            word_r <= '0;
            valid_r <= 1'b0;
            count_r <= '0;
            gap_r <= '0;
        end else begin
            beat_r <= beat_nxt;
            word_r <= word_nxt;
            valid_r <= valid_nxt;
            count_r <= count_nxt;
            gap_r <= gap_nxt;
        end
    end

    assign word_o.valid = valid_r;
    assign word_o.data = pcfg_pkg::WORD_W'(word_r);

    // ----------------------------------------------------------------
    // Wishbone slave and flags
    // ----------------------------------------------------------------
    logic [2:0] ctrl_nxt;
    logic ack_r, ack_nxt, mode_err_r, mode_err_nxt, early_r, early_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic req, wr0;

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    // Writes land at the edge that samples ack high, as the master sees it
    assign wr0 = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];

    always_comb begin
        ctrl_nxt = ctrl_r;
        ack_nxt = req;
        dat_nxt = dat_r;
        mode_err_nxt = mode_err_r;
        early_nxt = early_r;
        if (wr0 && wb_adr_i == pcfg_pkg::REG_CTRL) begin
            // Both stream modes at once is refused; old mode kept
            if (wb_dat_i[pcfg_pkg::CTRL_ENC] && wb_dat_i[pcfg_pkg::CTRL_COMP]) begin
                mode_err_nxt = 1'b1;
            end else begin
                ctrl_nxt = wb_dat_i[2:0];
            end
        end
        if (wr0 && wb_adr_i == pcfg_pkg::REG_STATUS) begin
            if (wb_dat_i[pcfg_pkg::STAT_MODE_ERR]) mode_err_nxt = 1'b0;
            if (wb_dat_i[pcfg_pkg::STAT_EARLY_CLK]) early_nxt = 1'b0;
        end
        // Set after clear so a same-cycle event is not lost
        if (early_ev) early_nxt = 1'b1;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                pcfg_pkg::REG_CTRL: dat_nxt = {29'h0, ctrl_r};
                pcfg_pkg::REG_STATUS: dat_nxt = {28'h0, beat_r != 4'h0, early_r,
                                                 mode_err_r, released_r};
                pcfg_pkg::REG_WORD: dat_nxt = 32'(word_r);
                pcfg_pkg::REG_COUNT: dat_nxt = count_r;
                default: dat_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= pcfg_pkg::CTRL_RESET;
            ack_r <= 1'b0;
            dat_r <= '0;
            mode_err_r <= 1'b0;
            early_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            mode_err_r <= mode_err_nxt;
            early_r <= early_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_status_low;
        @(posedge clk_i) disable iff (rst_i)
        (!status_n_o && por_cnt_r < por_target - 32'h1) |=> !status_n_o;
    endproperty
    a_status_low: assert property (p_status_low) else $error("status released early");

    property p_release_at_target;
        @(posedge clk_i) disable iff (rst_i)
        (sup_s2_r && !released_r && por_cnt_r == por_target - 32'h1) |=> status_n_o;
    endproperty
    a_release_at_target: assert property (p_release_at_target) else $error("no release");

    property p_supply_loss;
        @(posedge clk_i) disable iff (rst_i)
        !sup_s2_r |=> !status_n_o && por_cnt_r == 32'h0;
    endproperty
    a_supply_loss: assert property (p_supply_loss) else $error("supply loss ignored");

    property p_mode_excl;
        @(posedge clk_i) disable iff (rst_i)
        !(ctrl_r[pcfg_pkg::CTRL_ENC] && ctrl_r[pcfg_pkg::CTRL_COMP]);
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("both stream modes on");

    property p_ratio_done;
        @(posedge clk_i) disable iff (rst_i)
        (released_r && ck_rise && beat_r == ratio - 4'h1) |=> word_o.valid && beat_r == 4'h0;
    endproperty
    a_ratio_done: assert property (p_ratio_done) else $error("word not consumed");

    property p_no_early_valid;
        @(posedge clk_i) disable iff (rst_i)
        (released_r && ck_rise && beat_r < ratio - 4'h1) |=> !word_o.valid;
    endproperty
    a_no_early_valid: assert property (p_no_early_valid) else $error("word too soon");

    property p_capture;
        @(posedge clk_i) disable iff (rst_i)
        (released_r && ck_rise && beat_r == 4'h0) |=> word_r == $past(dat_s2_r);
    endproperty
    a_capture: assert property (p_capture) else $error("word not captured");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        (beat_r != 4'h0 || !ck_rise) |=> $stable(word_r);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed mid ratio");

    property p_early_flag;
        @(posedge clk_i) disable iff (rst_i)
        early_ev |=> early_r;
    endproperty
    a_early_flag: assert property (p_early_flag) else $error("early edge missed");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bad ack timing");

endmodule

`default_nettype wire

//--- tb/pcfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcfg_host_model #(
    parameter int unsigned DATA_W = 16
) (
    input wire logic status_n_i,
    output logic config_clock_o,
    output logic [DATA_W-1:0] config_data_o
);
    realtime rel_t = 0.0;

    initial begin
        config_clock_o = 1'b0;
        config_data_o = '0;
    end

    always @(posedge status_n_i) begin
        rel_t = $realtime;
    end

    // ----------------------------------------------------------------
    // One frame of edges
    // ----------------------------------------------------------------
    // Clock idles low outside frames; data lines show the inverse after
    task automatic send(input logic [DATA_W-1:0] w, input int edges, input logic early);
        if (!early && $realtime < rel_t + 10000.0) begin
            #(rel_t + 10000.0 - $realtime);
        end
        for (int i = 0; i < edges; i++) begin
            config_data_o <= w;
            #62.5 config_clock_o = 1'b1;
            #62.5 config_clock_o = 1'b0;
        end
        config_data_o <= ~w;
    endtask
endmodule

`default_nettype wire

//--- tb/tb_pcfg_intake.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pcfg_intake;
    localparam int unsigned DW = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_we_i, wb_cyc_i, wb_stb_i, supply_ok_i, wb_ack_o, status_n_o, cfg_clk;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [DW-1:0] cfg_dat, w;
    pcfg_pkg::pcfg_word_type word_o;
    int error_cnt = 0;
    int checks_done = 0;
    int cnt_exp = 0;
    int valid_cnt = 0;
    int ratio [3] = '{1, 2, 4};

    always #5 clk_i = ~clk_i;

    // Valid pulses counted where the output has settled
    always @(negedge clk_i) begin
        if (word_o.valid === 1'b1) begin
            valid_cnt++;
        end
    end

    pcfg_intake #(.DATA_W(DW), .POR_FAST_CYC(50), .POR_STD_CYC(100)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_ok_i(supply_ok_i),
        .config_clock_i(cfg_clk), .config_data_i(cfg_dat), .status_n_o(status_n_o),
        .word_o(word_o));

    pcfg_host_model #(.DATA_W(DW)) host (
        .status_n_i(status_n_o), .config_clock_o(cfg_clk), .config_data_o(cfg_dat));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask

    // Classic cycle: held until ack is sampled high, released at that edge
    task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n == 20) begin
            check(1'b0, 1'b1, "wb_ack");
            end_sim;
        end
    endtask

    task automatic wait_release(input int lo);
        int k;
        k = 0;
        @(posedge clk_i);
        supply_ok_i <= 1'b1;
        while (status_n_o !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        check(k >= lo && k <= lo + 5, 1'b1, "por_delay");
        if (k == 400) begin
            end_sim;
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        supply_ok_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(status_n_o, 32'h0, "status_n");
        wb(pcfg_pkg::REG_CTRL, 1'b0, 32'h0, rd);
        check(rd, 32'h0, "ctrl");
        wb(4'h2, 1'b1, 32'hff, rd);
        wb(4'h2, 1'b0, 32'h0, rd);
        check(rd, 32'h0, "unmapped");
        // Edges before release must be ignored
        host.send(16'h1234, 1, 1'b1);
        repeat (5) @(posedge clk_i);
        wb(pcfg_pkg::REG_COUNT, 1'b0, 32'h0, rd);
        check(rd, 32'h0, "count_gated");
        $display("Test reset and gating done");

        wait_release(50);
        host.send(16'ha5c3, 1, 1'b1);
        cnt_exp = 1;
        repeat (5) @(posedge clk_i);
        wb(pcfg_pkg::REG_STATUS, 1'b0, 32'h0, rd);
        check(rd, 32'h5, "status_early");
        check(word_o.data, 32'ha5c3, "word_o");
        wb(pcfg_pkg::REG_STATUS, 1'b1, 32'h4, rd);
        wb(pcfg_pkg::REG_STATUS, 1'b0, 32'h0, rd);
        check(rd, 32'h1, "status_clr");
        $display("Test release done");

        // Plain, encrypted, compressed: the mode index is the ctrl value
        for (int m = 0; m < 3; m++) begin
            wb(pcfg_pkg::REG_CTRL, 1'b1, 32'(m), rd);
            w = 16'h3c00 + 16'(m);
            host.send(w, ratio[m] - 1, 1'b0);
            repeat (5) @(posedge clk_i);
            if (ratio[m] > 1) begin
                wb(pcfg_pkg::REG_COUNT, 1'b0, 32'h0, rd);
                check(rd, 32'(cnt_exp), "count_mid");
                wb(pcfg_pkg::REG_STATUS, 1'b0, 32'h0, rd);
                check(rd, 32'h9, "status_mid");
            end
            host.send(~w, 1, 1'b0);
            cnt_exp++;
            repeat (5) @(posedge clk_i);
            wb(pcfg_pkg::REG_COUNT, 1'b0, 32'h0, rd);
            check(rd, 32'(cnt_exp), "count");
            wb(pcfg_pkg::REG_WORD, 1'b0, 32'h0, rd);
            // Ratio 1 takes the last word sent; longer groups keep the first
            check(rd, {16'h0, (ratio[m] > 1) ? w : ~w}, "word");
        end
        check(valid_cnt, cnt_exp, "valid_pulses");
        $display("Test ratios done");

        wb(pcfg_pkg::REG_CTRL, 1'b1, 32'h3, rd);
        wb(pcfg_pkg::REG_CTRL, 1'b0, 32'h0, rd);
        check(rd, 32'h2, "ctrl_kept");
        wb(pcfg_pkg::REG_STATUS, 1'b0, 32'h0, rd);
        check(rd, 32'h3, "mode_err");
        wb(pcfg_pkg::REG_STATUS, 1'b1, 32'h2, rd);
        wb(pcfg_pkg::REG_STATUS, 1'b0, 32'h0, rd);
        check(rd, 32'h1, "mode_err_clr");
        $display("Test mode conflict done");

        wb(pcfg_pkg::REG_CTRL, 1'b1, 32'h4, rd);
        @(posedge clk_i);
        supply_ok_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        check(status_n_o, 32'h0, "status_drop");
        wait_release(100);
        $display("Test standard delay done");
        end_sim;
    end
endmodule

`default_nettype wire
